// >>> hw/irs_pkg.sv
// Shared constants, states and carriers for the infrared serial transmitter codec.
package irs_pkg;

  localparam logic [3:0] BIT_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_PHASE = 4'h7;
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  localparam logic [3:0] MARK_BITS = 4'h1;
  localparam logic [3:0] RX_BITS_8 = 4'h9;
  localparam logic [3:0] RX_BITS_9 = 4'hA;
  localparam logic [3:0] DEC_HOLD_MAX = 4'h7;
  localparam logic [3:0] DEC_TERMINAL = 4'hF;
  localparam logic [1:0] JITTER_TICKS = 2'h2;

  localparam logic [1:0] PW_3_16 = 2'h0;
  localparam logic [1:0] PW_1_16 = 2'h1;
  localparam logic [1:0] PW_1_32 = 2'h2;
  localparam logic [1:0] PULSE_3_16_TICKS = 2'h3;
  localparam logic [1:0] PULSE_1_16_TICKS = 2'h1;
  localparam logic [1:0] PULSE_1_32_TICKS = 2'h1;

  localparam logic [10:0] DIV_MIN = 11'h001;
  localparam logic [11:0] DIV_CNT_RESET = 12'h000;
  localparam logic [10:0] SHIFT_IDLE = 11'h7FF;
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_PREAMBLE = 3'b001,
    TX_DATA = 3'b010,
    TX_BREAK = 3'b011,
    TX_MARK = 3'b100
  } irs_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10
  } irs_rx_state_t;

  typedef struct packed {
    logic block_enable;
    logic transmitter_enable;
    logic send_break;
    logic char_9bit;
    logic tx_bit_eight;
    logic ir_enable;
    logic [1:0] pulse_width_sel;
    logic baud_clock_select;
    logic [10:0] baud_divisor;
    logic tx_empty_int_en;
    logic tx_complete_int_en;
  } irs_ctrl_t;

  typedef struct packed {
    logic tx_empty_flag;
    logic tx_complete_flag;
    logic rx_full_flag;
    logic framing_error_flag;
    logic break_flag;
    logic rx_bit_eight;
  } irs_status_t;

endpackage

// >>> hw/irs_baud_gen.sv
// Baud reference generator producing 32x and 16x baud tick strobes.
`timescale 1ns/1ns
module irs_baud_gen (
  input wire logic clk,
  input wire logic srst,
  input wire logic src_tick,
  input wire logic [10:0] divisor,
  output logic tick32,
  output logic tick16
);
  import irs_pkg::*;

  logic [11:0] cnt;
  logic [11:0] last;
  logic half;

  // A 32x period is two source periods per divisor step, so one bit is 64 x divisor.
  assign last = {((divisor == 11'h000) ? DIV_MIN : divisor), 1'b0} - 12'h001;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= DIV_CNT_RESET;
      tick32 <= 1'b0;
    end else begin
      tick32 <= 1'b0;
      if (src_tick) begin
        if (cnt >= last) begin
          cnt <= DIV_CNT_RESET;
          tick32 <= 1'b1;
        end else begin
          cnt <= cnt + 12'h001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      half <= 1'b0;
      tick16 <= 1'b0;
    end else begin
      tick16 <= tick32 & half;
      if (tick32) begin
        half <= ~half;
      end
    end
  end

endmodule // irs_baud_gen

// >>> hw/irs_ir_decoder.sv
// Infrared receive decoder that stretches narrow low pulses into zero bits.
`timescale 1ns/1ns
module irs_ir_decoder (
  input wire logic clk,
  input wire logic srst,
  input wire logic tick16,
  input wire logic pin_sync,
  output logic decoded_receive_out
);
  import irs_pkg::*;

  logic prev;
  logic pend;
  logic fall;
  logic hit;
  logic running;
  logic [3:0] cnt;
  logic [1:0] guard;

  // Pulses may be shorter than a 16x period, so an edge is held until the next tick.
  assign fall = prev & ~pin_sync;
  assign hit = tick16 & (pend | fall);

  always_ff @(posedge clk) begin
    if (srst) begin
      prev <= 1'b1;
      pend <= 1'b0;
    end else begin
      prev <= pin_sync;
      if (tick16) begin
        pend <= 1'b0;
      end else if (fall) begin
        pend <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      running <= 1'b0;
      cnt <= DEC_TERMINAL;
      decoded_receive_out <= 1'b1;
      guard <= 2'h0;
    end else if (tick16) begin
      if (!running) begin
        if (guard != 2'h0) begin
          guard <= guard - 2'h1;
        end else if (hit) begin
          running <= 1'b1;
          cnt <= 4'h0;
          decoded_receive_out <= 1'b0;
        end
      end else if (hit && (cnt > DEC_HOLD_MAX)) begin
        cnt <= 4'h0;
      end else if (cnt == DEC_TERMINAL - 4'h1) begin
        cnt <= DEC_TERMINAL;
        decoded_receive_out <= 1'b1;
        running <= 1'b0;
        guard <= JITTER_TICKS;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end

endmodule // irs_ir_decoder

// >>> hw/irs_top.sv
// Infrared serial codec: transmitter, encoder, receiver break detection and pin control.
`timescale 1ns/1ns
module irs_top (
  input wire logic clk,
  input wire logic srst,
  input wire irs_pkg::irs_ctrl_t ctrl,
  input wire logic oscillator_ref_clock,
  input wire logic data_write,
  input wire logic [7:0] data_in,
  input wire logic status_read,
  input wire logic rx_read,
  input wire logic rxd_pin,
  output logic txd_out,
  output logic txd_oe_n,
  output irs_pkg::irs_status_t status,
  output logic [7:0] rx_data,
  output logic tx_int_req
);
  import irs_pkg::*;

  // Clock source and baud references.

  logic osc_meta;
  logic osc_sync;
  logic osc_prev;
  logic src_tick;
  logic tick32;
  logic tick16;

  always_ff @(posedge clk) begin
    if (srst) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= oscillator_ref_clock;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  // The oscillator is sampled, so it must run well below half the bus clock.
  assign src_tick = ctrl.baud_clock_select ? (osc_sync & ~osc_prev) : 1'b1;

  irs_baud_gen u_baud (
    .clk(clk),
    .srst(srst),
    .src_tick(src_tick),
    .divisor(ctrl.baud_divisor),
    .tick32(tick32),
    .tick16(tick16)
  );

  // Data buffer and transmitter-empty handshake.

  logic [7:0] buf_data;
  logic buf_full;
  logic empty_armed;
  logic tx_load;
  logic tx_empty;

  always_ff @(posedge clk) begin
    if (srst) begin
      buf_data <= DATA_RESET;
      buf_full <= 1'b0;
    end else if (data_write) begin
      buf_data <= data_in;
      buf_full <= 1'b1;
    end else if (tx_load) begin
      buf_full <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      empty_armed <= 1'b0;
    end else if (data_write) begin
      empty_armed <= 1'b0;
    end else if (status_read && tx_empty) begin
      empty_armed <= 1'b1;
    end
  end

  // A transfer in the same cycle as a clearing write keeps the flag set.
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_empty <= 1'b1;
    end else if (tx_load) begin
      tx_empty <= 1'b1;
    end else if (data_write && empty_armed) begin
      tx_empty <= 1'b0;
    end
  end

  // Transmit sequencer.

  irs_tx_state_t state;
  irs_tx_state_t next_state;
  logic [10:0] shreg;
  logic [10:0] next_shreg;
  logic [3:0] bits_left;
  logic [3:0] next_bits;
  logic [3:0] frame_bits;
  logic [3:0] phase;
  logic bit_end;
  logic char_end;
  logic bit_start;
  logic te_prev;
  logic preamble_due;
  logic te;

  assign te = ctrl.transmitter_enable;
  assign frame_bits = ctrl.char_9bit ? FRAME_BITS_9 : FRAME_BITS_8;
  assign bit_end = (state != TX_IDLE) && tick16 && (phase == BIT_LAST);
  // Leaving idle only on a 16x tick keeps the first bit of a character a full bit time.
  assign char_end = ((state == TX_IDLE) && tick16) || (bit_end && (bits_left == 4'h1));
  assign tx_load = char_end && (next_state == TX_DATA);

  // A rising enable, even mid-character, owes one idle character.
  always_ff @(posedge clk) begin
    if (srst || !ctrl.block_enable) begin
      te_prev <= 1'b0;
      preamble_due <= 1'b0;
    end else begin
      te_prev <= te;
      if (te && !te_prev) begin
        preamble_due <= 1'b1;
      end else if (!te || (char_end && next_state == TX_PREAMBLE)) begin
        preamble_due <= 1'b0;
      end
    end
  end

  always_comb begin
    next_state = TX_IDLE;
    next_shreg = SHIFT_IDLE;
    next_bits = frame_bits;
    if (te && ctrl.send_break) begin
      next_state = TX_BREAK;
      next_shreg = '0;
    end else if (state == TX_BREAK) begin
      next_state = TX_MARK;
      next_bits = MARK_BITS;
    end else if (te && preamble_due) begin
      next_state = TX_PREAMBLE;
    end else if (te && buf_full) begin
      next_state = TX_DATA;
      next_shreg = {1'b1, ctrl.char_9bit ? ctrl.tx_bit_eight : 1'b1, buf_data, 1'b0};
    end
  end

  // A disable stops the sequencer at once and the line is released below.
  always_ff @(posedge clk) begin
    if (srst || !ctrl.block_enable) begin
      state <= TX_IDLE;
      shreg <= SHIFT_IDLE;
      bits_left <= 4'h0;
      phase <= 4'h0;
      bit_start <= 1'b0;
    end else begin
      bit_start <= 1'b0;
      if (char_end) begin
        state <= next_state;
        shreg <= next_shreg;
        bits_left <= next_bits;
        phase <= 4'h0;
        bit_start <= (next_state != TX_IDLE);
      end else if (bit_end) begin
        shreg <= {1'b1, shreg[10:1]};
        bits_left <= bits_left - 4'h1;
        phase <= 4'h0;
        bit_start <= 1'b1;
      end else if (tick16) begin
        phase <= phase + 4'h1;
      end
    end
  end

  // Infrared encoder.

  logic [1:0] pulse_left;
  logic [1:0] pulse_width;
  logic width_tick;
  logic line_low;
  logic tick16_d;

  always_comb begin
    pulse_width = PULSE_3_16_TICKS;
    width_tick = tick16_d;
    case (ctrl.pulse_width_sel)
      PW_1_16: begin
        pulse_width = PULSE_1_16_TICKS;
      end
      PW_1_32: begin
        pulse_width = PULSE_1_32_TICKS;
        width_tick = tick32;
      end
      default: begin
        pulse_width = PULSE_3_16_TICKS;
      end
    endcase
  end

  // Every pulse is launched at a bit boundary, so two zeros are one bit apart.
  // The launch lags the boundary by one clock, so the 16x tick is delayed to keep the full width.
  always_ff @(posedge clk) begin
    if (srst || !ctrl.block_enable) begin
      pulse_left <= 2'h0;
      tick16_d <= 1'b0;
    end else begin
      tick16_d <= tick16;
      if (bit_start && !shreg[0]) begin
        pulse_left <= pulse_width;
      end else if (pulse_left != 2'h0 && width_tick) begin
        pulse_left <= pulse_left - 2'h1;
      end
    end
  end

  // Idle shift contents are all ones, so the line rests high.
  assign line_low = ctrl.ir_enable ? (pulse_left != 2'h0) : !shreg[0];

  // The pin is open drain: it only ever pulls low and relies on the pull-up for one.
  assign txd_out = 1'b0;

  always_ff @(posedge clk) begin
    if (srst) begin
      txd_oe_n <= 1'b1;
    end else begin
      txd_oe_n <= !(ctrl.block_enable && line_low);
    end
  end

  // Transmission complete and request outputs.

  logic tx_complete;

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_complete <= 1'b1;
    end else begin
      tx_complete <= (state == TX_IDLE) && !buf_full;
    end
  end

  assign tx_int_req = (tx_empty && ctrl.tx_empty_int_en) || (tx_complete && ctrl.tx_complete_int_en);

  // Receive path.

  logic rx_meta;
  logic rx_sync;
  logic ir_rx;
  logic rx_in;

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rxd_pin;
      rx_sync <= rx_meta;
    end
  end

  irs_ir_decoder u_dec (
    .clk(clk),
    .srst(srst),
    .tick16(tick16),
    .pin_sync(rx_sync),
    .decoded_receive_out(ir_rx)
  );

  assign rx_in = ctrl.ir_enable ? ir_rx : rx_sync;

  irs_rx_state_t rx_state;
  logic [3:0] rx_phase;
  logic [3:0] rx_count;
  logic [9:0] rx_sh;
  logic [9:0] rx_vec;
  logic rx_sample;
  logic rx_done;
  logic rx_is_break;

  assign rx_sample = tick16 && (rx_phase == SAMPLE_PHASE);
  assign rx_vec = {rx_in, rx_sh[9:1]};
  assign rx_done = (rx_state == RX_BITS) && rx_sample
    && (rx_count == (ctrl.char_9bit ? RX_BITS_9 : RX_BITS_8) - 4'h1);
  assign rx_is_break = (rx_vec == 10'h000);

  always_ff @(posedge clk) begin
    if (srst || !ctrl.block_enable) begin
      rx_state <= RX_IDLE;
      rx_phase <= 4'h0;
      rx_count <= 4'h0;
      rx_sh <= 10'h000;
    end else if (tick16) begin
      rx_phase <= rx_phase + 4'h1;
      case (rx_state)
        RX_IDLE: begin
          rx_phase <= 4'h0;
          if (!rx_in) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_sample) begin
            rx_state <= rx_in ? RX_IDLE : RX_BITS;
            rx_count <= 4'h0;
            rx_sh <= 10'h000;
          end
        end
        RX_BITS: begin
          if (rx_sample) begin
            rx_sh <= rx_vec;
            rx_count <= rx_count + 4'h1;
            if (rx_done) begin
              rx_state <= RX_IDLE;
            end
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  logic rx_full;
  logic rx_fe;
  logic rx_brk;
  logic rx_b8;

  // Flags set by a finished character win over a read in the same cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_full <= 1'b0;
      rx_fe <= 1'b0;
      rx_brk <= 1'b0;
      rx_data <= DATA_RESET;
      rx_b8 <= 1'b0;
    end else if (rx_done) begin
      rx_full <= 1'b1;
      rx_fe <= !rx_in;
      rx_brk <= rx_is_break;
      if (rx_is_break) begin
        rx_data <= DATA_RESET;
        rx_b8 <= 1'b0;
      end else if (ctrl.char_9bit) begin
        rx_data <= rx_vec[7:0];
        rx_b8 <= rx_vec[8];
      end else begin
        rx_data <= rx_vec[8:1];
        rx_b8 <= rx_vec[8];
      end
    end else if (rx_read) begin
      rx_full <= 1'b0;
      rx_fe <= 1'b0;
      rx_brk <= 1'b0;
    end
  end

  assign status.tx_empty_flag = tx_empty;
  assign status.tx_complete_flag = tx_complete;
  assign status.rx_full_flag = rx_full;
  assign status.framing_error_flag = rx_fe;
  assign status.break_flag = rx_brk;
  assign status.rx_bit_eight = rx_b8;

endmodule // irs_top

// >>> test/irs_top_monitor.sv
// Port-level concurrent checks for the infrared serial codec.
`timescale 1ns/1ns
module irs_top_monitor
  import irs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire irs_pkg::irs_ctrl_t ctrl,
  input wire logic data_write,
  input wire logic status_read,
  input wire logic rx_read,
  input wire logic txd_oe_n,
  input wire irs_pkg::irs_status_t status,
  input wire logic [7:0] rx_data,
  input wire logic tx_int_req
);
  logic [11:0] low_run;
  logic [11:0] gap;
  logic gap_ok;
  logic [11:0] pw_len;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // Runs saturate so a long break train cannot wrap into a false bit multiple.
  always_ff @(posedge clk) begin
    if (srst || txd_oe_n) low_run <= 12'h000;
    else if (low_run != 12'hFFF) low_run <= low_run + 12'h001;
  end

  always_ff @(posedge clk) begin
    if (srst) gap <= 12'hFFF;
    else if ($fell(txd_oe_n)) gap <= 12'h001;
    else if (gap != 12'hFFF) gap <= gap + 12'h001;
  end

  always_ff @(posedge clk) begin
    if (srst || !ctrl.ir_enable) gap_ok <= 1'b0;
    else if ($fell(txd_oe_n)) gap_ok <= 1'b1;
  end

  // One bit is 64 clocks at divisor one, so 3/16 is 12 clocks.
  assign pw_len = (ctrl.pulse_width_sel == PW_1_16) ? 12'h004 :
                  (ctrl.pulse_width_sel == PW_1_32) ? 12'h002 : 12'h00C;

  oe_release_a: assert property (!ctrl.block_enable |=> txd_oe_n)
    else $error("transmit pin not released after block disable");
  int_req_a: assert property (tx_int_req == ((status.tx_empty_flag && ctrl.tx_empty_int_en) ||
    (status.tx_complete_flag && ctrl.tx_complete_int_en)))
    else $error("transmit request does not match flags and enables");
  empty_clear_a: assert property ((status_read && status.tx_empty_flag) ##1 (data_write && !status_read)
    |=> !status.tx_empty_flag)
    else $error("empty flag not cleared by read then write");
  idle_high_a: assert property ((!ctrl.transmitter_enable && status.tx_complete_flag) [*2] |-> txd_oe_n)
    else $error("idle transmitter drives the pin low");
  bit_run_a: assert property ($rose(txd_oe_n) && !ctrl.ir_enable && ctrl.block_enable &&
    $past(ctrl.block_enable) && low_run != 12'hFFF |-> low_run[5:0] == 6'h00)
    else $error("low run is not a whole number of bits");
  ir_width_a: assert property ($rose(txd_oe_n) && ctrl.ir_enable && $past(ctrl.block_enable)
    |-> low_run == pw_len)
    else $error("infrared pulse width wrong");
  ir_space_a: assert property ($fell(txd_oe_n) && gap_ok && gap < 12'h280 |-> gap[5:0] == 6'h00)
    else $error("infrared pulse starts not on bit spacing");
  rx_break_a: assert property ($rose(status.break_flag) |-> status.framing_error_flag &&
    status.rx_full_flag && rx_data == 8'h00 && !status.rx_bit_eight)
    else $error("break flags or data wrong");
  rx_clear_a: assert property (rx_read |=> !status.rx_full_flag && !status.break_flag)
    else $error("receive flags not cleared by read");

  cover property ($rose(status.break_flag));
  cover property ($fell(status.tx_empty_flag));
  cover property ($rose(txd_oe_n) && ctrl.ir_enable);
endmodule // irs_top_monitor

// >>> test/irs_peer.sv
// Remote serial device: drives the receive pin and samples the transmit line.
`timescale 1ns/1ns
module irs_peer (
  input wire logic clk,
  input wire logic line,
  output logic rxd
);
  // The receive pin has a pull-up, so one is both mark and released level.
  initial rxd = 1'b1;

  task automatic send(input logic [10:0] bits, input logic [3:0] n, input logic ir);
    for (int i = 0; i < n; i++) begin
      @(negedge clk) rxd <= bits[i];
      if (ir && !bits[i]) begin
        repeat (12) @(negedge clk);
        rxd <= 1'b1;
        repeat (51) @(negedge clk);
      end else begin
        repeat (63) @(negedge clk);
      end
    end
    @(negedge clk) rxd <= 1'b1;
  endtask

  // Samples mid-bit from the first low, LSB first.
  task automatic recv(output logic [10:0] bits, input logic [3:0] n);
    bits = 11'h7FF;
    @(negedge clk);
    while (line) @(negedge clk);
    repeat (32) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = line;
      repeat (64) @(negedge clk);
    end
  endtask
endmodule // irs_peer

// >>> test/irs_top_tb.sv
// Self-checking bench for the infrared serial codec.
`timescale 1ns/1ns
module irs_top_tb;
  import irs_pkg::*;
  logic clk;
  logic srst;
  irs_ctrl_t ctrl;
  logic osc;
  logic data_write;
  logic [7:0] data_in;
  logic status_read;
  logic rx_read;
  logic rxd_pin;
  logic txd_out;
  logic txd_oe_n;
  irs_status_t status;
  logic [7:0] rx_data;
  logic tx_int_req;
  logic tx_line;
  int mismatches;
  int checked;

  // Open-drain transmit pin with a pull-up.
  assign tx_line = txd_oe_n ? 1'b1 : txd_out;

  irs_top u_dut(.clk(clk), .srst(srst), .ctrl(ctrl), .oscillator_ref_clock(osc),
    .data_write(data_write), .data_in(data_in), .status_read(status_read), .rx_read(rx_read),
    .rxd_pin(rxd_pin), .txd_out(txd_out), .txd_oe_n(txd_oe_n), .status(status),
    .rx_data(rx_data), .tx_int_req(tx_int_req));
  irs_peer u_peer(.clk(clk), .line(tx_line), .rxd(rxd_pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    forever #37 osc = ~osc;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic load(input logic [7:0] d);
    @(negedge clk) status_read = 1'b1;
    @(negedge clk) status_read = 1'b0;
    data_write = 1'b1;
    data_in = d;
    @(negedge clk) data_write = 1'b0;
  endtask

  task automatic te_start();
    @(negedge clk) ctrl.transmitter_enable = 1'b0;
    @(negedge clk) ctrl.transmitter_enable = 1'b1;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (status.tx_complete_flag !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk("tx_complete", 16'h0001, status.tx_complete_flag);
  endtask

  task automatic t_frame(input logic [7:0] d, input logic m9, input logic b8);
    logic [10:0] bits;
    ctrl.char_9bit = m9;
    ctrl.tx_bit_eight = b8;
    te_start();
    load(d);
    chk("tx_empty_clear", 16'h0000, status.tx_empty_flag);
    u_peer.recv(bits, m9 ? 4'hB : 4'hA);
    chk("frame", m9 ? {1'b1, b8, d, 1'b0} : {2'b11, d, 1'b0}, bits);
    chk("tx_empty_set", 16'h0001, status.tx_empty_flag);
    ctrl.transmitter_enable = 1'b0;
    wait_done();
  endtask

  task automatic t_ir(input logic [1:0] sel, input logic [15:0] w);
    logic [15:0] n;
    ctrl.ir_enable = 1'b1;
    ctrl.pulse_width_sel = sel;
    te_start();
    load(8'h00);
    n = 0;
    while (tx_line && n < 2000) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (!tx_line && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("ir_width", w, n);
    while (tx_line && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("ir_spacing", 16'h0040, n);
    // Dropping the enable mid-character must still let the character finish.
    ctrl.transmitter_enable = 1'b0;
    wait_done();
    ctrl.ir_enable = 1'b0;
  endtask

  task automatic t_break();
    logic [10:0] bits;
    logic [15:0] n;
    ctrl.char_9bit = 1'b0;
    @(negedge clk) ctrl.transmitter_enable = 1'b1;
    ctrl.send_break = 1'b1;
    u_peer.recv(bits, 4'hA);
    chk("break_char", 16'h0400, bits);
    ctrl.send_break = 1'b0;
    n = 0;
    while (!tx_line && n < 1500) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (tx_line && n < 64) begin
      @(negedge clk);
      n++;
    end
    chk("break_mark", 16'h0040, n);
    ctrl.transmitter_enable = 1'b0;
    wait_done();
  endtask

  task automatic t_release();
    te_start();
    load(8'h00);
    while (tx_line) @(negedge clk);
    repeat (70) @(negedge clk);
    chk("data_low", 16'h0000, tx_line);
    ctrl.block_enable = 1'b0;
    @(negedge clk);
    chk("pin_release", 16'h0001, txd_oe_n);
    ctrl.transmitter_enable = 1'b0;
    ctrl.block_enable = 1'b1;
    wait_done();
  endtask

  task automatic t_rx(input logic ir, input logic [9:0] frame, input logic [15:0] exp);
    ctrl.ir_enable = ir;
    u_peer.send({1'b1, frame}, 4'hA, ir);
    repeat (8) @(negedge clk);
    chk("rx_result", exp, {2'b00, status, rx_data});
    @(negedge clk) rx_read = 1'b1;
    @(negedge clk) rx_read = 1'b0;
    chk("rx_cleared", 16'h0000, {status.rx_full_flag, status.framing_error_flag, status.break_flag});
    ctrl.ir_enable = 1'b0;
  endtask

  task automatic t_int();
    ctrl.tx_empty_int_en = 1'b1;
    @(negedge clk);
    chk("int_empty", 16'h0001, tx_int_req);
    ctrl.tx_empty_int_en = 1'b0;
    ctrl.tx_complete_int_en = 1'b1;
    @(negedge clk);
    chk("int_complete", 16'h0001, tx_int_req);
    ctrl.tx_complete_int_en = 1'b0;
    @(negedge clk);
    chk("int_masked", 16'h0000, tx_int_req);
  endtask

  initial begin
    mismatches = 0;
    checked = 0;
    ctrl = '0;
    ctrl.baud_divisor = 11'h001;
    srst = 1'b1;
    data_write = 1'b0;
    data_in = 8'h00;
    status_read = 1'b0;
    rx_read = 1'b0;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk("reset_state", {1'b0, 1'b1, 6'b110000, 8'h00}, {1'b0, txd_oe_n, status, rx_data});
    ctrl.block_enable = 1'b1;
    t_int();
    t_frame(8'hA5, 1'b0, 1'b0);
    t_frame(8'h3C, 1'b1, 1'b1);
    t_frame(8'hC3, 1'b1, 1'b0);
    t_ir(PW_3_16, 16'h000C);
    t_ir(PW_1_16, 16'h0004);
    t_ir(PW_1_32, 16'h0002);
    t_ir(2'h3, 16'h000C);
    t_break();
    t_release();
    t_rx(1'b0, 10'h000, {2'b00, 6'b111110, 8'h00});
    t_rx(1'b1, {1'b1, 8'h7F, 1'b0}, {2'b00, 6'b111000, 8'h7F});
    finish_test();
  end

  // The whole sequence needs roughly 14000 cycles; this leaves ample margin.
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    finish_test();
  end
endmodule // irs_top_tb

bind irs_top irs_top_monitor u_mon(.clk(clk), .srst(srst), .ctrl(ctrl), .data_write(data_write),
  .status_read(status_read), .rx_read(rx_read), .txd_oe_n(txd_oe_n), .status(status),
  .rx_data(rx_data), .tx_int_req(tx_int_req));
